/* dv/asr_line_tx.sv */
// Behavioural remote transmitter driving the serial receive line
module asr_line_tx
#(
    parameter int BIT_CYC = 16
)
(
    input  wire logic clk,
    output logic      line
);
    timeunit 1ns;
    timeprecision 1ps;

    logic inv;
    int   bc;

    // Idle at mark; mark is low once polarity is inverted
    initial
    begin
        inv  = 1'b0;
        bc   = BIT_CYC;
        line = 1'b1;
    end

    // Bit length in clocks, to follow the baud rate under test
    task automatic set_rate(input int n);
        bc = n;
    endtask

    // Change polarity only while idle, then hold the new idle level for a bit
    task automatic set_inv(input logic v);
        inv = v;
        line <= ~v;
        repeat (BIT_CYC) @(posedge clk);
    endtask

    // Start, data, stop, one idle bit; frame bit gb+1 gets a one-cycle glitch mid-bit
    task automatic send(input logic [8:0] d, input int nbits, input logic stop, input int gb);
        logic [11:0] f;
        f = {1'b1, 1'b1, d, 1'b0};
        f[nbits + 1] = stop;
        for (int j = 0; j < nbits + 3; j++)
        begin
            line <= f[j] ^ inv;
            repeat (bc / 2) @(posedge clk);
            line <= f[j] ^ inv ^ (j == gb + 1);
            @(posedge clk);
            line <= f[j] ^ inv;
            repeat (bc / 2 - 1) @(posedge clk);
        end
    endtask

    // Low pulse far shorter than half a bit, then two idle bits
    task automatic false_start();
        line <= inv;
        repeat (BIT_CYC / 4) @(posedge clk);
        line <= ~inv;
        repeat (BIT_CYC * 2) @(posedge clk);
    endtask
endmodule

/* dv/testbench.sv */
// Self-checking bench for the asynchronous serial receiver
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import asr_pkg::*;

    localparam int          BIT = 16;
    localparam int          NG  = 20;
    localparam logic [31:0] ALL = 32'hFFFFFFFF;
    localparam logic [31:0] PEN = 32'h1 << RSC_PORT_EN;
    localparam logic [31:0] ON  = PEN | (32'h1 << RSC_CONT_RX);
    localparam logic [7:0]  CORNER [4] = '{8'h00, 8'hFF, 8'h01, 8'h80};

    logic        MCLK, RESET_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, SERIAL_IN_PIN, RX_IRQ, RX_PENDING, err;
    logic [7:0]  PADDR, d;
    logic [31:0] PWDATA, PRDATA, seed, rd;
    int          miscompares, tests_run, k;

    // Divisor 0 with high speed gives one tick per clock, so a bit is 16 clocks
    asr_receiver dut
    (
        .MCLK(MCLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .SERIAL_IN_PIN(SERIAL_IN_PIN), .RX_IRQ(RX_IRQ), .RX_PENDING(RX_PENDING)
    );
    // Partner drives the receive pin as a plain digital input
    asr_line_tx #(.BIT_CYC(BIT)) tx (.clk(MCLK), .line(SERIAL_IN_PIN));

    // 250 MHz clock
    initial
    begin
        MCLK = 1'b0;
        forever #2 MCLK = ~MCLK;
    end

    task automatic close_out();
        $display("Checks %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One APB transfer; data and error are taken at the edge that sees PREADY
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge MCLK);
        {PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {1'b1, 1'b0, w, a, wd};
        @(posedge MCLK);
        PENABLE <= 1'b1;
        n = 0;
        do @(posedge MCLK); while (PREADY !== 1'b1 && n++ < 64);
        rd = PRDATA;
        err = PSLVERR;
        {PSEL, PENABLE} <= 2'b00;
        if (PREADY !== 1'b1)
        begin
            chk("PREADY", 32'h1, {31'h0, PREADY});
            close_out();
        end
    endtask

    task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
        apb(1'b0, a, 32'h0);
        chk(nm, exp & m, rd & m);
    endtask

    // Pending flag is registered, so let two edges pass before looking
    task automatic pend(input string nm, input logic exp);
        repeat (2) @(posedge MCLK);
        chk(nm, {31'h0, exp}, {31'h0, RX_PENDING});
    endtask

    task automatic wait_pend();
        for (int n = 0; n < 1000 && RX_PENDING !== 1'b1; n++)
            @(posedge MCLK);
        chk("RX_PENDING wait", 32'h1, {31'h0, RX_PENDING});
        if (RX_PENDING !== 1'b1)
            close_out();
    endtask

    function automatic logic [7:0] rnd8();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction

    // Expected status with port and receive enabled
    function automatic logic [31:0] rsc(input logic nine, input logic fe, input logic oe, input logic b9);
        return ON | ({31'h0, nine} << RSC_NINE_BIT) | ({31'h0, fe} << RSC_FRAME_ERR)
            | ({31'h0, oe} << RSC_OVERRUN) | ({31'h0, b9} << RSC_NINTH);
    endfunction

    // Status is read before data, because the data read advances the buffer
    task automatic rx_char(input logic [8:0] c, input logic nine, input int gb);
        tx.send(c, nine ? 9 : 8, 1'b1, gb);
        wait_pend();
        rc("status", REG_RX_STATUS_CTRL, rsc(nine, 1'b0, 1'b0, nine & c[8]), ALL);
        rc("data", REG_RX_DATA, {24'h0, c[7:0]}, ALL);
        pend("RX_PENDING drained", 1'b0);
    endtask

    initial
    begin
        miscompares = 0;
        tests_run = 0;
        seed = 32'h9CCC;
        {RESET_N, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
        repeat (8) @(posedge MCLK);
        RESET_N <= 1'b1;
        // Reset values; the idle status bit of baud control is masked
        rc("rst status", REG_RX_STATUS_CTRL, {24'h0, RST_RSC}, ALL);
        rc("rst baud", REG_BAUD_CTRL, {24'h0, RST_BAUD}, ~32'h40);
        rc("rst div", REG_DIV_LOW, {24'h0, RST_DIV}, ALL);
        rc("rst tx status", REG_TX_STATUS_CTRL, {24'h0, RST_TSC}, ALL);
        rc("rst irq", REG_IRQ_CTRL, {24'h0, RST_IRQ}, ALL);
        apb(1'b0, 8'h1C, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, err});
        d = rnd8();
        apb(1'b1, REG_DIV_HIGH, {24'h0, d});
        rc("div rw", REG_DIV_HIGH, {24'h0, d}, ALL);
        apb(1'b1, REG_DIV_HIGH, 32'h0);
        apb(1'b1, REG_TX_STATUS_CTRL, 32'h1 << TSC_BRGH);
        apb(1'b1, REG_RX_STATUS_CTRL, ON);
        // Corner then random characters; random ones carry a glitch on one data bit
        for (k = 0; k < 8; k++)
        begin
            d = (k < 4) ? CORNER[k] : rnd8();
            rx_char({1'b0, d}, 1'b0, (k < 4) ? NG : k);
        end
        apb(1'b1, REG_RX_STATUS_CTRL, ON | (32'h1 << RSC_NINE_BIT));
        rx_char({1'b1, rnd8()}, 1'b1, NG);
        apb(1'b1, REG_RX_STATUS_CTRL, ON);
        apb(1'b1, REG_BAUD_CTRL, 32'h1 << BC_RX_INVERT);
        tx.set_inv(1'b1);
        rx_char({1'b0, 8'h3C}, 1'b0, NG);
        apb(1'b1, REG_BAUD_CTRL, 32'h0);
        tx.set_inv(1'b0);
        tx.false_start();
        pend("false start", 1'b0);
        rx_char({1'b0, 8'h5A}, 1'b0, NG);
        // Bad stop then good character, back to back
        tx.send({1'b0, 8'hC3}, 8, 1'b0, NG);
        tx.send({1'b0, 8'h96}, 8, 1'b1, NG);
        rc("frame_error_flag first", REG_RX_STATUS_CTRL, rsc(1'b0, 1'b1, 1'b0, 1'b0), ALL);
        rc("data first", REG_RX_DATA, 32'hC3, ALL);
        rc("frame_error_flag next", REG_RX_STATUS_CTRL, rsc(1'b0, 1'b0, 1'b0, 1'b0), ALL);
        rc("data next", REG_RX_DATA, 32'h96, ALL);
        // Interrupt needs all three enables; pending bit cannot be written
        tx.send({1'b0, 8'h11}, 8, 1'b1, NG);
        wait_pend();
        for (k = 0; k < 16; k++)
        begin
            apb(1'b1, REG_IRQ_CTRL, 32'(k));
            repeat (2) @(posedge MCLK);
            chk("RX_IRQ", {31'h0, k % 8 == 7}, {31'h0, RX_IRQ});
            rc("irq ctrl", REG_IRQ_CTRL, 32'((k & 7) | 8), ALL);
        end
        rc("irq data", REG_RX_DATA, 32'h11, ALL);
        repeat (2) @(posedge MCLK);
        chk("RX_IRQ empty", 32'h0, {31'h0, RX_IRQ});
        // Third character into a full buffer, then a fourth that must be refused
        for (k = 0; k < 3; k++)
            tx.send({1'b0, 8'h20 + k[7:0]}, 8, 1'b1, NG);
        rc("overrun set", REG_RX_STATUS_CTRL, rsc(1'b0, 1'b0, 1'b1, 1'b0), ALL);
        tx.send({1'b0, 8'h7E}, 8, 1'b1, NG);
        rc("ovr data 0", REG_RX_DATA, 32'h20, ALL);
        rc("ovr data 1", REG_RX_DATA, 32'h21, ALL);
        // Empty read repeats the last entry and pops nothing
        rc("ovr empty", REG_RX_DATA, 32'h21, ALL);
        rc("ovr held", REG_RX_STATUS_CTRL, rsc(1'b0, 1'b0, 1'b1, 1'b0), ALL);
        apb(1'b1, REG_RX_STATUS_CTRL, PEN);
        rc("ovr cleared", REG_RX_STATUS_CTRL, PEN, ALL);
        apb(1'b1, REG_RX_STATUS_CTRL, ON);
        rx_char({1'b0, 8'h42}, 1'b0, NG);
        // Receive disable keeps framing status; port disable forces it clear
        tx.send({1'b0, 8'h0F}, 8, 1'b0, NG);
        wait_pend();
        apb(1'b1, REG_RX_STATUS_CTRL, PEN);
        pend("rx disabled", 1'b0);
        rc("frame_error_flag kept", REG_RX_STATUS_CTRL, PEN | (32'h1 << RSC_FRAME_ERR), ALL);
        apb(1'b1, REG_RX_STATUS_CTRL, 32'h0);
        rc("frame_error_flag forced", REG_RX_STATUS_CTRL, 32'h0, ALL);
        apb(1'b1, REG_RX_STATUS_CTRL, ON);
        pend("port reset", 1'b0);
        // Clocked mode selected: the asynchronous receiver must stay deaf
        apb(1'b1, REG_TX_STATUS_CTRL, (32'h1 << TSC_BRGH) | (32'h1 << TSC_SYNC));
        tx.send({1'b0, 8'hA5}, 8, 1'b1, NG);
        pend("sync deaf", 1'b0);
        // Low speed: four clocks per tick, so a bit lasts four times longer
        apb(1'b1, REG_TX_STATUS_CTRL, 32'h0);
        tx.set_rate(BIT * 4);
        rx_char({1'b0, rnd8()}, 1'b0, NG);
        close_out();
    end
endmodule

/* rtl/asr_pkg.sv */
// Package of register map, field positions and types for the asynchronous serial receiver
package asr_pkg;

    // Register byte offsets on the APB slave
    localparam logic [7:0] REG_RX_STATUS_CTRL = 8'h00;
    localparam logic [7:0] REG_BAUD_CTRL      = 8'h04;
    localparam logic [7:0] REG_DIV_LOW        = 8'h08;
    localparam logic [7:0] REG_DIV_HIGH       = 8'h0C;
    localparam logic [7:0] REG_TX_STATUS_CTRL = 8'h10;
    localparam logic [7:0] REG_RX_DATA        = 8'h14;
    localparam logic [7:0] REG_IRQ_CTRL       = 8'h18;

    // Receive status and control field positions
    localparam int RSC_PORT_EN   = 7;
    localparam int RSC_NINE_BIT  = 6;
    localparam int RSC_CONT_RX   = 4;
    localparam int RSC_FRAME_ERR = 2;
    localparam int RSC_OVERRUN   = 1;
    localparam int RSC_NINTH     = 0;

    // Baud control, transmit status and interrupt control field positions
    localparam int BC_RX_INVERT  = 5;
    localparam int BC_BRG16      = 3;
    localparam int TSC_SYNC      = 4;
    localparam int TSC_BRGH      = 2;
    localparam int IRQ_RX_EN     = 0;
    localparam int IRQ_PERIPH_EN = 1;
    localparam int IRQ_GLOBAL_EN = 2;

    // Reset values
    localparam logic [7:0] RST_RSC  = 8'h00;
    localparam logic [7:0] RST_BAUD = 8'h00;
    localparam logic [7:0] RST_DIV  = 8'h00;
    localparam logic [7:0] RST_TSC  = 8'h00;
    localparam logic [7:0] RST_IRQ  = 8'h00;

    // Oversampling and vote timing, in sixteenth-bit ticks
    localparam logic [3:0] OVS_LAST    = 4'hF;
    localparam logic [3:0] OVS_HALF    = 4'h7;
    localparam logic [3:0] VOTE_FIRST  = 4'h6;
    localparam logic [3:0] VOTE_SECOND = 4'h7;

    // Receive state machine
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_START = 2'b01,
        ST_DATA  = 2'b10,
        ST_STOP  = 2'b11
    } asr_state_t;

    // One buffered character with its status
    typedef struct packed {
        logic       frame_err;
        logic       ninth;
        logic [7:0] data;
    } asr_char_t;

    // APB request bundle
    typedef struct packed {
        logic        sel;
        logic        enable;
        logic        write;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } asr_apb_req_t;

endpackage

/* rtl/asr_receiver.sv */
// Asynchronous serial receiver with 16x oversampling, two-entry buffer and APB registers
// What this block does
// - Oversample line at sixteen times bit rate
// - Finished character goes into two-entry buffer
// - Falling edge, half bit, recheck start low
// - False start abandoned silently, resume watching
// - Full bit to each centre, majority vote
// - Stop sample zero records framing error
// - Push character and raise pending flag
// - Data read returns and removes oldest
// - Polarity bit resets zero, one inverts
// - Pending flag: enabled and buffer nonempty
// - Interrupt needs three enables all set
// - Framing status stored per character
// - Framing error blocks nothing, follows buffer
// - Port disable resets; receive disable keeps framing
// - Framing error alone raises no interrupt
// - Third character into full buffer sets overrun
// - Overrun keeps stored data, blocks reception
// - Overrun clears only by enable clears
// - Least significant bit first
// - Nine-bit mode, ninth bit readable
//
// Added by the designer: the APB slave port and the address map.
module asr_receiver
(
    input  wire logic        MCLK,
    input  wire logic        RESET_N,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        SERIAL_IN_PIN,
    output logic             RX_IRQ,
    output logic             RX_PENDING
);
    import asr_pkg::*;

    // Register file and bus state
    logic [7:0]   rsc_q, rsc_d;
    logic [7:0]   baud_q, baud_d;
    logic [7:0]   divl_q, divl_d;
    logic [7:0]   divh_q, divh_d;
    logic [7:0]   tsc_q, tsc_d;
    logic [7:0]   irq_q, irq_d;
    logic [31:0]  prdata_q, prdata_d;
    logic         pready_q, pready_d;
    logic         pslverr_q, pslverr_d;
    // Baud generator
    logic [15:0]  brg_q, brg_d;
    logic [1:0]   pre_q, pre_d;
    logic         tick;
    // Receiver
    asr_state_t   st_q, st_d;
    logic [3:0]   ovs_q, ovs_d;
    logic [3:0]   bit_q, bit_d;
    logic [8:0]   shf_q, shf_d;
    logic [1:0]   hist_q, hist_d;
    logic         prev_q, prev_d;
    // Buffer
    asr_char_t    buf_q [2];
    asr_char_t    buf_d [2];
    logic [1:0]   cnt_q, cnt_d;
    logic         ovr_q, ovr_d;
    logic         irq_out_q, irq_out_d;
    logic         pend_q, pend_d;

    asr_apb_req_t req;
    logic         acc_wr, acc_rd;
    logic         line;
    logic         vote;
    logic         port_en, rx_en;
    logic         push, pop;
    asr_char_t    new_char;

    assign req = '{sel: PSEL, enable: PENABLE, write: PWRITE, addr: PADDR, wdata: PWDATA};
    // Access completes in the setup-to-access cycle; slave always ready
    assign acc_wr  = req.sel && req.enable && req.write;
    assign acc_rd  = req.sel && req.enable && !req.write;
    assign port_en = rsc_q[RSC_PORT_EN];
    // Sync mode is not built; receiver stays idle while sync is selected
    assign rx_en   = port_en && rsc_q[RSC_CONT_RX] && !tsc_q[TSC_SYNC];

    // Polarity applied before any detection
    assign line = SERIAL_IN_PIN ^ baud_q[BC_RX_INVERT];

    // Two of three: held samples plus the present one
    assign vote = (hist_q[0] & hist_q[1]) | (hist_q[0] & line) | (hist_q[1] & line);

    // Shared baud generator: divide then prescale to a 16x tick
    always_comb
    begin
        brg_d = brg_q;
        pre_d = pre_q;
        tick  = 1'b0;
        if (!port_en)
        begin
            brg_d = 16'h0000;
            pre_d = 2'h0;
        end
        else if (brg_q == 16'h0000)
        begin
            brg_d = baud_q[BC_BRG16] ? {divh_q, divl_q} : {8'h00, divl_q};
            // Low speed divides by 64, high speed by 16; the 4x prescale makes 16x ticks
            tick  = tsc_q[TSC_BRGH] || pre_q == 2'h3;
            pre_d = tick ? 2'h0 : pre_q + 2'h1;
        end
        else
        begin
            brg_d = brg_q - 16'h0001;
        end
    end

    // Receive sequencer
    always_comb
    begin
        st_d     = st_q;
        ovs_d    = ovs_q;
        bit_d    = bit_q;
        shf_d    = shf_q;
        hist_d   = hist_q;
        prev_d   = prev_q;
        push     = 1'b0;
        new_char = '0;
        if (!rx_en)
        begin
            st_d   = ST_IDLE;
            prev_d = 1'b1;
        end
        else if (tick)
        begin
            hist_d = {hist_q[0], line};
            prev_d = line;
            ovs_d  = ovs_q + 4'h1;
            case (st_q)
                ST_IDLE:
                begin
                    // Overrun blocks new characters
                    if (prev_q && !line && !ovr_q)
                    begin
                        st_d  = ST_START;
                        ovs_d = 4'h0;
                    end
                end
                ST_START:
                begin
                    if (ovs_q == OVS_HALF)
                    begin
                        if (!vote)
                        begin
                            st_d  = ST_DATA;
                            ovs_d = OVS_HALF + 4'h1;
                            bit_d = 4'h0;
                        end
                        else
                        begin
                            st_d = ST_IDLE;
                        end
                    end
                end
                ST_DATA:
                begin
                    if (ovs_q == OVS_HALF)
                    begin
                        // LSB arrives first, so shift in from the top
                        shf_d = rsc_q[RSC_NINE_BIT] ? {vote, shf_q[8:1]} : {1'b0, vote, shf_q[7:1]};
                        bit_d = bit_q + 4'h1;
                        if (bit_q == (rsc_q[RSC_NINE_BIT] ? 4'h8 : 4'h7))
                        begin
                            st_d = ST_STOP;
                        end
                    end
                end
                ST_STOP:
                begin
                    if (ovs_q == OVS_HALF)
                    begin
                        push               = 1'b1;
                        new_char.data      = shf_q[7:0];
                        new_char.ninth     = shf_q[8];
                        new_char.frame_err = !vote;
                        st_d               = ST_IDLE;
                        prev_d             = vote;
                    end
                end
                default: st_d = ST_IDLE;
            endcase
        end
    end

    // Data read pops the oldest entry
    assign pop = acc_rd && req.addr == REG_RX_DATA && cnt_q != 2'h0;

    // Two-entry buffer, overrun and flags
    always_comb
    begin
        buf_d[0] = buf_q[0];
        buf_d[1] = buf_q[1];
        cnt_d    = cnt_q;
        ovr_d    = ovr_q;
        if (!port_en)
        begin
            // Port disable acts as module reset and clears framing state
            cnt_d    = 2'h0;
            ovr_d    = 1'b0;
            buf_d[0] = '0;
            buf_d[1] = '0;
        end
        else
        begin
            if (pop)
            begin
                buf_d[0] = buf_q[1];
                cnt_d    = cnt_q - 2'h1;
            end
            if (push)
            begin
                // Full buffer at stop bit: keep old data, flag overrun
                if (cnt_q == 2'h2 && !pop)
                begin
                    ovr_d = 1'b1;
                end
                else
                begin
                    buf_d[cnt_d[0]] = new_char;
                    cnt_d           = cnt_d + 2'h1;
                end
            end
            ovr_d = ovr_d && rsc_q[RSC_CONT_RX];
        end
        // Flag needs receiver enabled, not only data present
        pend_d    = rx_en && cnt_d != 2'h0;
        // Only the pending flag drives the request; framing errors never do
        irq_out_d = pend_d && irq_q[IRQ_RX_EN] && irq_q[IRQ_PERIPH_EN]
                    && irq_q[IRQ_GLOBAL_EN];
    end

    // Register writes and APB read data
    always_comb
    begin
        rsc_d     = rsc_q;
        baud_d    = baud_q;
        divl_d    = divl_q;
        divh_d    = divh_q;
        tsc_d     = tsc_q;
        irq_d     = irq_q;
        prdata_d  = 32'h0000_0000;
        pready_d  = 1'b1;
        pslverr_d = 1'b0;
        if (req.sel && !req.enable)
        begin
            // Setup cycle: prepare answer for the access phase
            case (req.addr)
                REG_RX_STATUS_CTRL:
                begin
                    // Framing and ninth bits read from the oldest entry; overrun from its own flag
                    prdata_d[7:0] = {rsc_q[7:3], buf_q[0].frame_err, ovr_q, buf_q[0].ninth};
                end
                REG_BAUD_CTRL:      prdata_d[7:0] = {baud_q[7], (st_q == ST_IDLE), baud_q[5:0]};
                REG_DIV_LOW:        prdata_d[7:0] = divl_q;
                REG_DIV_HIGH:       prdata_d[7:0] = divh_q;
                REG_TX_STATUS_CTRL: prdata_d[7:0] = tsc_q;
                REG_RX_DATA:        prdata_d[7:0] = buf_q[0].data;
                REG_IRQ_CTRL:       prdata_d[7:0] = {4'h0, pend_q, irq_q[2:0]};
                default:            pslverr_d = 1'b1;
            endcase
        end
        else if (acc_wr)
        begin
            pslverr_d = pslverr_q;
            case (req.addr)
                // Status bits are read-only in hardware state
                REG_RX_STATUS_CTRL: rsc_d  = {req.wdata[7:3], 3'h0};
                REG_BAUD_CTRL:      baud_d = {2'h0, req.wdata[5:3], 3'h0};
                REG_DIV_LOW:        divl_d = req.wdata[7:0];
                REG_DIV_HIGH:       divh_d = req.wdata[7:0];
                REG_TX_STATUS_CTRL: tsc_d  = {3'h0, req.wdata[4], 1'b0, req.wdata[2], 2'h0};
                REG_IRQ_CTRL:       irq_d  = {5'h0, req.wdata[2:0]};
                default:            pslverr_d = pslverr_q;
            endcase
        end
        else if (req.sel && req.enable)
        begin
            prdata_d  = prdata_q;
            pslverr_d = pslverr_q;
        end
    end

    // All state registered here
    always_ff @(posedge MCLK)
    begin
        if (!RESET_N)
        begin
            rsc_q     <= RST_RSC;
            baud_q    <= RST_BAUD;
            divl_q    <= RST_DIV;
            divh_q    <= RST_DIV;
            tsc_q     <= RST_TSC;
            irq_q     <= RST_IRQ;
            prdata_q  <= 32'h0000_0000;
            pready_q  <= 1'b1;
            pslverr_q <= 1'b0;
            brg_q     <= 16'h0000;
            pre_q     <= 2'h0;
            st_q      <= ST_IDLE;
            ovs_q     <= 4'h0;
            bit_q     <= 4'h0;
            shf_q     <= 9'h000;
            hist_q    <= 2'h3;
            prev_q    <= 1'b1;
            buf_q[0]  <= '0;
            buf_q[1]  <= '0;
            cnt_q     <= 2'h0;
            ovr_q     <= 1'b0;
            pend_q    <= 1'b0;
            irq_out_q <= 1'b0;
        end
        else
        begin
            rsc_q     <= rsc_d;
            baud_q    <= baud_d;
            divl_q    <= divl_d;
            divh_q    <= divh_d;
            tsc_q     <= tsc_d;
            irq_q     <= irq_d;
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
            brg_q     <= brg_d;
            pre_q     <= pre_d;
            st_q      <= st_d;
            ovs_q     <= ovs_d;
            bit_q     <= bit_d;
            shf_q     <= shf_d;
            hist_q    <= hist_d;
            prev_q    <= prev_d;
            buf_q[0]  <= buf_d[0];
            buf_q[1]  <= buf_d[1];
            cnt_q     <= cnt_d;
            ovr_q     <= ovr_d;
            pend_q    <= pend_d;
            irq_out_q <= irq_out_d;
        end
    end

    assign PRDATA     = prdata_q;
    assign PREADY     = pready_q;
    assign PSLVERR    = pslverr_q;
    assign RX_IRQ     = irq_out_q;
    assign RX_PENDING = pend_q;

    // Pending flag tracks enable and occupancy
    pend_flag_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
        pend_q == (rx_en && cnt_q != 2'h0) || $past(cnt_q) != cnt_q || $changed(rx_en))
        else $error("pending flag disagrees with buffer");
    // Interrupt never without all enables
    irq_gate_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
        irq_out_q |-> ($past(irq_q[IRQ_RX_EN]) && $past(irq_q[IRQ_PERIPH_EN]) && $past(irq_q[IRQ_GLOBAL_EN])))
        else $error("interrupt raised without enables");
    // Framing error alone never interrupts
    frame_noirq_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
        irq_out_q |-> $past(pend_d))
        else $error("interrupt without pending character");
    // Buffer never exceeds two
    buf_depth_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
        cnt_q <= 2'h2)
        else $error("buffer count above two");
    // Overrun only from a push into a full buffer
    ovr_set_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
        $rose(ovr_q) |-> $past(push) && $past(cnt_q) == 2'h2)
        else $error("overrun set without full buffer");
    // Overrun clears only through enables
    ovr_clear_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
        $fell(ovr_q) |-> (!$past(rsc_q[RSC_CONT_RX]) || !$past(port_en)))
        else $error("overrun cleared without enable clear");
    // Overrun holds stored characters
    ovr_hold_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
        (ovr_q && !pop && port_en) |=> cnt_q == $past(cnt_q))
        else $error("buffer changed during overrun");
    // False start returns to idle without a push
    false_start_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
        (st_q == ST_START && tick && rx_en && ovs_q == OVS_HALF && vote) |=> st_q == ST_IDLE && cnt_q == $past(cnt_q))
        else $error("false start not abandoned");
    // Port disable clears the buffer
    port_reset_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
        !port_en |=> cnt_q == 2'h0 && !buf_q[0].frame_err)
        else $error("port disable did not reset");

endmodule
